// ==== core/pcitp_pkg.sv ====
package pcitp_pkg;

    // ------------------------
    // Widths
    // ------------------------
    localparam int AD_W  = 32;
    localparam int CBE_W = 4;
    localparam int BYTE_W = 8;

    // ------------------------
    // Command register bit positions
    // ------------------------
    localparam int CMD_PERR_EN_BIT = 6;
    localparam int CMD_SERR_EN_BIT = 8;
    localparam int CMD_W           = 16;

    // ------------------------
    // Bus commands
    // ------------------------
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_IO_RD  = 4'h2;
    localparam logic [3:0] CMD_IO_WR  = 4'h3;

    // ------------------------
    // Timing
    // ------------------------
    localparam int         CLK_PERIOD_NS     = 25;
    localparam int         DEVSEL_TMO_CLKS   = 5;
    localparam logic [2:0] DEVSEL_TMO_CNT    = 3'(DEVSEL_TMO_CLKS);
    localparam logic [2:0] CNT_ZERO          = 3'h0;
    localparam logic [2:0] CNT_ONE           = 3'h1;

    // ------------------------
    // Carriers
    // ------------------------
    typedef struct packed {
        logic [AD_W-1:0]  ad;
        logic [CBE_W-1:0] cbe;
    } pcitp_adcbe_t;

    typedef struct packed {
        logic             write;
        logic [AD_W-1:0]  addr;
        logic [3:0]       cmd;
        logic [AD_W-1:0]  wdata;
        logic [CBE_W-1:0] be;
        logic             last;
    } pcitp_mreq_t;

    typedef struct packed {
        logic             write;
        logic             cfg;
        logic [AD_W-1:0]  addr;
        logic [AD_W-1:0]  wdata;
        logic [CBE_W-1:0] be;
    } pcitp_tacc_t;

endpackage

// ==== core/pcitp_sync2.sv ====
`timescale 1ns/10ps
module pcitp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d_in;
            q_ff    <= meta_ff;
        end
    end

    assign q_out = q_ff;
endmodule

// ==== core/pcitp_parity.sv ====
`timescale 1ns/10ps
module pcitp_parity
    import pcitp_pkg::*;
(
    input  wire pcitp_adcbe_t bus_in,
    output logic              par_out
);
    // Even parity: AD, C/BE and PAR together carry an even count of ones
    assign par_out = ^{bus_in.ad, bus_in.cbe};
endmodule

// ==== core/pcitp_port.sv ====
// Functional notes
// - AD carries the address in the address phase, data in data phases.
// - C/BE carries the command in the address phase, byte enables later.
// - Byte enable n qualifies AD bits 8n+7 down to 8n.
// - Even parity is computed over all AD and C/BE lines together.
// - As initiator, PAR is driven one clock after the covered phase.
// - As target, parity mismatch with initiator's PAR asserts parity error.
// - Parity error drive only while command bit 6 is set.
// - With command bit 8 set, system error pulses on any system error.
// - System error also pulses on a secondary side address parity error.
// - DEVSEL is asserted to claim cycles decoded as addressed to us.
// - As initiator, no DEVSEL before timeout ends cycle with master abort.
// - Initiator holds FRAME while more follow; releases it on last phase.
// - Data phase completes only on an edge with IRDY and TRDY asserted.
// - REQ asserted whenever a transaction as initiator is pending.
// - A grant is used only while a request is pending.
// - Configuration accesses are claimed only with IDSEL asserted.
// - Target STOP ends our initiator cycle; our target stops bursts.
// - All bus inputs are sampled on the rising clock edge.
// - During bus reset all outputs float and state clears to default.
`timescale 1ns/10ps
module pcitp_port
    import pcitp_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    input  wire logic              bus_reset_in,
    // Bus pins, active-low signals carry _n
    input  wire logic [AD_W-1:0]   ad_in,
    output logic      [AD_W-1:0]   ad_out,
    output logic                   ad_oe_out,
    input  wire logic [CBE_W-1:0]  cbe_n_in,
    output logic      [CBE_W-1:0]  cbe_n_out,
    output logic                   cbe_oe_out,
    input  wire logic              par_in,
    output logic                   par_out,
    output logic                   par_oe_out,
    input  wire logic              frame_n_in,
    output logic                   frame_n_out,
    output logic                   frame_oe_out,
    input  wire logic              irdy_n_in,
    output logic                   irdy_n_out,
    output logic                   irdy_oe_out,
    input  wire logic              trdy_n_in,
    output logic                   trdy_n_out,
    output logic                   trdy_oe_out,
    input  wire logic              devsel_n_in,
    output logic                   devsel_n_out,
    output logic                   devsel_oe_out,
    input  wire logic              stop_n_in,
    output logic                   stop_n_out,
    output logic                   stop_oe_out,
    input  wire logic              perr_n_in,
    output logic                   perr_n_out,
    output logic                   perr_oe_out,
    output logic                   serr_n_out,
    output logic                   serr_oe_out,
    output logic                   req_n_out,
    output logic                   req_oe_out,
    input  wire logic              gnt_n_in,
    input  wire logic              idsel_in,
    // Core side
    input  wire logic [CMD_W-1:0]  cmd_reg_in,
    input  wire logic [AD_W-1:0]   bar_base_in,
    input  wire logic [AD_W-1:0]   bar_mask_in,
    input  wire logic              sys_err_in,
    input  wire logic              sec_addr_perr_in,
    input  wire logic              mreq_valid_in,
    input  wire pcitp_mreq_t       mreq_in,
    output logic                   mreq_ready_out,
    output logic                   mdone_out,
    output logic                   mabort_out,
    output logic                   mstop_out,
    output logic      [AD_W-1:0]   mrdata_out,
    output logic                   tacc_valid_out,
    output pcitp_tacc_t            tacc_out,
    input  wire logic [AD_W-1:0]   trdata_in,
    output logic                   perr_seen_out
);
    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int SYNC_W = AD_W + CBE_W + 9;
    logic [SYNC_W-1:0] sync_q;
    logic              brst;
    logic              rst;
    logic [AD_W-1:0]   ad_s;
    logic [CBE_W-1:0]  cbe_s;
    logic par_s, frame_s, irdy_s, trdy_s, devsel_s, stop_s, perr_s, gnt_s, idsel_s;

    pcitp_sync2 #(.W(1)) u_rsync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .d_in        (bus_reset_in),
        .q_out       (brst)
    );
    pcitp_sync2 #(.W(SYNC_W)) u_bsync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .d_in        ({ad_in, cbe_n_in, par_in, ~frame_n_in, ~irdy_n_in, ~trdy_n_in,
                       ~devsel_n_in, ~stop_n_in, ~perr_n_in, ~gnt_n_in, idsel_in}),
        .q_out       (sync_q)
    );
    assign {ad_s, cbe_s, par_s, frame_s, irdy_s, trdy_s, devsel_s, stop_s, perr_s, gnt_s, idsel_s} = sync_q;
    assign rst = rst_in | brst;

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_MADDR = 7'h02,
        ST_MDATA = 7'h04,
        ST_MTURN = 7'h08,
        ST_TDATA = 7'h10,
        ST_TTURN = 7'h20,
        ST_TWAIT = 7'h40
    } pcitp_state_t;

    pcitp_state_t state_ff;
    pcitp_state_t nxt_state;
    logic [2:0]   tmo_cnt_ff;
    logic         mwr_ff;
    logic         par_rx_ff;
    logic         twr_ff;
    logic         par_pend_ff;
    logic         par_chk_ff;
    logic         phase_done;
    logic         claim;
    logic         cfg_hit;
    logic         mem_hit;
    logic         par_calc;
    logic         par_rx;
    pcitp_adcbe_t drv_ff;
    pcitp_adcbe_t rx_bus;

    assign rx_bus.ad  = ad_s;
    assign rx_bus.cbe = cbe_s;
    assign phase_done = irdy_s & trdy_s;

    pcitp_parity u_ptx (.bus_in(drv_ff), .par_out(par_calc));
    pcitp_parity u_prx (.bus_in(rx_bus), .par_out(par_rx));

    // Address decode of a new frame
    always_comb begin
        cfg_hit = 1'b0;
        mem_hit = 1'b0;
        if ((cbe_s == CMD_CFG_RD) || (cbe_s == CMD_CFG_WR)) begin
            cfg_hit = idsel_s;
        end else if ((cbe_s == CMD_MEM_RD) || (cbe_s == CMD_MEM_WR) ||
                     (cbe_s == CMD_IO_RD) || (cbe_s == CMD_IO_WR)) begin
            mem_hit = ((ad_s & bar_mask_in) == bar_base_in);
        end
    end
    assign claim = frame_s & ~irdy_s & (cfg_hit | mem_hit);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (claim) begin
                    nxt_state = ST_TDATA;
                end else if (mreq_valid_in & gnt_s & ~frame_s & ~irdy_s) begin
                    nxt_state = ST_MADDR;
                end
            end
            ST_MADDR: nxt_state = ST_MDATA;
            ST_MDATA: begin
                if ((phase_done & mreq_in.last) || stop_s || (~devsel_s && tmo_cnt_ff == CNT_ZERO)) begin
                    nxt_state = ST_MTURN;
                end
            end
            ST_MTURN: nxt_state = ST_IDLE;
            ST_TDATA: begin
                if (phase_done) begin
                    nxt_state = ST_TTURN;
                end
            end
            ST_TTURN: nxt_state = frame_s ? ST_TWAIT : ST_IDLE;
            ST_TWAIT: nxt_state = frame_s ? ST_TWAIT : ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // DEVSEL timeout counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            tmo_cnt_ff <= CNT_ZERO;
        end else if (state_ff == ST_MADDR) begin
            tmo_cnt_ff <= DEVSEL_TMO_CNT;
        end else if (state_ff == ST_MDATA && !devsel_s && tmo_cnt_ff != CNT_ZERO) begin
            tmo_cnt_ff <= tmo_cnt_ff - CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Driven AD and C/BE
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            drv_ff <= '0;
            mwr_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && nxt_state == ST_MADDR) begin
            drv_ff.ad  <= mreq_in.addr;
            drv_ff.cbe <= mreq_in.cmd;
            mwr_ff     <= mreq_in.write;
        end else if (state_ff == ST_MADDR) begin
            drv_ff.ad  <= mreq_in.write ? mreq_in.wdata : '0;
            drv_ff.cbe <= ~mreq_in.be;
        end else if (state_ff == ST_IDLE && claim) begin
            drv_ff.ad  <= trdata_in;
            drv_ff.cbe <= '0;
        end
    end

    // ------------------------------------------------------------
    // PAR drive one clock after the covered phase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            par_out     <= 1'b0;
            par_pend_ff <= 1'b0;
        end else begin
            par_pend_ff <= (state_ff == ST_MADDR) || (state_ff == ST_MDATA && mwr_ff);
            par_out     <= par_calc;
        end
    end

    // ------------------------------------------------------------
    // Target side
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            tacc_out       <= '0;
            tacc_valid_out <= 1'b0;
            twr_ff         <= 1'b0;
        end else begin
            tacc_valid_out <= 1'b0;
            if (state_ff == ST_IDLE && claim) begin
                tacc_out.addr  <= ad_s;
                tacc_out.cfg   <= cfg_hit;
                tacc_out.write <= cbe_s[0];
                twr_ff         <= cbe_s[0];
            end else if (state_ff == ST_TDATA && phase_done) begin
                for (int i = 0; i < CBE_W; i++) begin
                    tacc_out.wdata[i*BYTE_W +: BYTE_W] <= cbe_s[i] ? '0 : ad_s[i*BYTE_W +: BYTE_W];
                end
                tacc_out.be    <= ~cbe_s;
                tacc_valid_out <= 1'b1;
            end
        end
    end

    // Parity check one clock after a received write phase
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            par_chk_ff    <= 1'b0;
            par_rx_ff     <= 1'b0;
            perr_seen_out <= 1'b0;
            perr_n_out    <= 1'b1;
        end else begin
            par_chk_ff    <= (state_ff == ST_TDATA) & phase_done & twr_ff;
            par_rx_ff     <= par_rx;
            perr_seen_out <= par_chk_ff & (par_rx_ff != par_s);
            perr_n_out    <= ~(par_chk_ff & (par_rx_ff != par_s) & cmd_reg_in[CMD_PERR_EN_BIT]);
        end
    end

    // ------------------------------------------------------------
    // System error pulse
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            serr_n_out <= 1'b1;
        end else begin
            serr_n_out <= ~(cmd_reg_in[CMD_SERR_EN_BIT] & (sys_err_in | sec_addr_perr_in));
        end
    end

    // ------------------------------------------------------------
    // Initiator results
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            mdone_out  <= 1'b0;
            mabort_out <= 1'b0;
            mstop_out  <= 1'b0;
            mrdata_out <= '0;
        end else begin
            mdone_out  <= (state_ff == ST_MDATA) & phase_done;
            mabort_out <= (state_ff == ST_MDATA) & ~devsel_s & (tmo_cnt_ff == CNT_ZERO);
            mstop_out  <= (state_ff == ST_MDATA) & stop_s;
            if (state_ff == ST_MDATA && phase_done && !mwr_ff) begin
                mrdata_out <= ad_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic mact;
    logic tact;
    assign mact           = (state_ff == ST_MADDR) || (state_ff == ST_MDATA);
    assign tact           = (state_ff == ST_TDATA);
    assign mreq_ready_out = (state_ff == ST_IDLE) && (nxt_state == ST_MADDR);
    assign req_n_out      = ~mreq_valid_in | rst;
    assign req_oe_out     = ~rst;
    assign ad_out         = drv_ff.ad;
    assign ad_oe_out      = ~rst & ((state_ff == ST_MADDR) | (state_ff == ST_MDATA & mwr_ff) | (tact & ~twr_ff));
    assign cbe_n_out      = drv_ff.cbe;
    assign cbe_oe_out     = ~rst & mact;
    assign par_oe_out     = ~rst & par_pend_ff;
    assign frame_n_out    = ~((state_ff == ST_MADDR) | (state_ff == ST_MDATA & ~mreq_in.last));
    assign frame_oe_out   = ~rst & mact;
    assign irdy_n_out     = ~(state_ff == ST_MDATA);
    assign irdy_oe_out    = ~rst & ((state_ff == ST_MDATA) | (state_ff == ST_MTURN));
    assign devsel_n_out   = ~tact;
    assign devsel_oe_out  = ~rst & (tact | (state_ff == ST_TTURN));
    assign trdy_n_out     = ~tact;
    assign trdy_oe_out    = ~rst & (tact | (state_ff == ST_TTURN));
    assign stop_n_out     = ~(tact & frame_s);
    assign stop_oe_out    = ~rst & (tact | (state_ff == ST_TTURN));
    assign perr_oe_out    = ~rst & ~perr_n_out;
    assign serr_oe_out    = ~rst & ~serr_n_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    perr_gate_a: assert property (@(posedge core_clk_in) disable iff (rst)
        !perr_n_out |-> $past(cmd_reg_in[CMD_PERR_EN_BIT]))
        else $error("parity error driven while disabled");
    serr_gate_a: assert property (@(posedge core_clk_in) disable iff (rst)
        !serr_n_out |-> $past(cmd_reg_in[CMD_SERR_EN_BIT]))
        else $error("system error driven while disabled");
    serr_cause_a: assert property (@(posedge core_clk_in) disable iff (rst)
        (cmd_reg_in[CMD_SERR_EN_BIT] && sec_addr_perr_in) |=> !serr_n_out)
        else $error("secondary parity error missed");
    par_delay_a: assert property (@(posedge core_clk_in) disable iff (rst)
        (state_ff == ST_MADDR) |=> par_oe_out && (par_out == $past(par_calc)))
        else $error("address parity late");
    mabort_tmo_a: assert property (@(posedge core_clk_in) disable iff (rst)
        (state_ff == ST_MADDR) ##1 (!devsel_s && !stop_s && !phase_done) [*6] |=> mabort_out)
        else $error("master abort missing");
    cfg_idsel_a: assert property (@(posedge core_clk_in) disable iff (rst)
        (state_ff == ST_IDLE && nxt_state == ST_TDATA && (cbe_s == CMD_CFG_RD || cbe_s == CMD_CFG_WR))
        |-> idsel_s)
        else $error("configuration claimed without IDSEL");
    tdone_hs_a: assert property (@(posedge core_clk_in) disable iff (rst)
        tacc_valid_out |-> $past(irdy_s && trdy_s))
        else $error("data phase completed without both ready");
    frame_last_a: assert property (@(posedge core_clk_in) disable iff (rst)
        (state_ff == ST_MDATA && mreq_in.last) |-> frame_n_out && !irdy_n_out)
        else $error("frame held in last data phase");
    par_even_a: assert property (@(posedge core_clk_in) disable iff (rst)
        par_oe_out |-> (^{$past(ad_out), $past(cbe_n_out), par_out}) == 1'b0)
        else $error("parity not even");
endmodule

// ==== bench/pcitp_bus_agent.sv ====
`timescale 1ns/10ps
module pcitp_bus_agent
    import pcitp_pkg::*;
(
    input  wire logic [1:0]       mode_in,
    input  wire logic             core_clk_in,
    input  wire logic [3:0]       dly_in,
    input  wire logic [AD_W-1:0]  ad_in,
    input  wire logic [CBE_W-1:0] cbe_n_in,
    input  wire logic             frame_n_in,
    input  wire logic             irdy_n_in,
    output logic      [AD_W-1:0]  ad_out,
    output logic                  ad_oe_out,
    output logic                  devsel_n_out,
    output logic                  trdy_n_out,
    output logic                  stop_n_out
);
    // ------------------------
    // Target: mode 0 claims, 1 silent, 2 stops, 3 off
    // ------------------------
    logic            frame_d_ff = 1'b1;
    logic            busy_ff = 1'b0;
    logic            rd_ff = 1'b0;
    logic [3:0]      cnt_ff = 4'h0;
    logic [AD_W-1:0] addr_ff = '0;
    initial begin
        {ad_oe_out, devsel_n_out, trdy_n_out, stop_n_out} = 4'h7;
        ad_out = '0;
    end
    always @(posedge core_clk_in) begin
        frame_d_ff <= frame_n_in;
        if (!busy_ff && frame_d_ff && !frame_n_in && !mode_in[0]) begin
            busy_ff <= 1'b1;
            rd_ff <= !cbe_n_in[0];
            addr_ff <= ad_in;
            cnt_ff <= 4'h0;
        end
        if (busy_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == 4'h1) devsel_n_out <= 1'b0;
            if (cnt_ff == 4'h1 + dly_in) begin
                trdy_n_out <= mode_in[1];
                stop_n_out <= !mode_in[1];
                ad_oe_out <= rd_ff;
                ad_out <= addr_ff ^ 32'hA5A5_0F0F;
            end
            if (!trdy_n_out && !irdy_n_in || !stop_n_out && irdy_n_in && frame_n_in) begin
                busy_ff <= 1'b0;
                {ad_oe_out, devsel_n_out, trdy_n_out, stop_n_out} <= 4'h7;
            end
        end
    end
endmodule

// ==== bench/pcitp_port_tb_top.sv ====
`timescale 1ns/10ps
module pcitp_port_tb_top;
    import pcitp_pkg::*;
    // ------------------------
    // Bus wiring, pull-ups on control lines
    // ------------------------
    logic             core_clk_in = 1'b0, rst_in = 1'b1, bus_reset_in = 1'b0, gnt_n_in = 1'b0, idsel_in = 1'b0;
    logic             sys_err_in = 1'b0, sec_addr_perr_in = 1'b0, mreq_valid_in = 1'b0, perr_n_in = 1'b1;
    logic             b_oe = 1'b0, b_poe = 1'b0, b_par = 1'b0, b_frame = 1'b1, b_irdy = 1'b1;
    logic [3:0]       b_cbe = 4'hF, cyc = 4'h0, dly = 4'h0;
    logic [1:0]       mode = 2'h3;
    logic [CMD_W-1:0] cmd_reg_in = 16'h0140;
    logic [AD_W-1:0]  b_ad = 32'h0, p_ad, ad_in, ad_out, mrdata_out, trdata_in = 32'h0;
    logic [AD_W-1:0]  bar_base_in = 32'h4000_0000, bar_mask_in = 32'hF000_0000;
    logic [3:0]       cbe_n_in, cbe_n_out;
    logic             par_in, frame_n_in, irdy_n_in, trdy_n_in, devsel_n_in, stop_n_in, p_oe, p_dev, p_trdy, p_stop;
    logic             ad_oe_out, cbe_oe_out, par_out, par_oe_out, frame_n_out, frame_oe_out, irdy_n_out, irdy_oe_out;
    logic             trdy_n_out, trdy_oe_out, devsel_n_out, devsel_oe_out, stop_n_out, stop_oe_out, perr_n_out;
    logic             perr_oe_out, serr_n_out, serr_oe_out, req_n_out, req_oe_out, mreq_ready_out, mdone_out;
    logic             mabort_out, mstop_out, tacc_valid_out, perr_seen_out;
    pcitp_mreq_t      mreq_in = '0;
    pcitp_tacc_t      tacc_out;
    pcitp_tacc_t      exp_q[$];
    int               seed = 40470, error_cnt = 0, n_tests = 0, n_dev = 0, n_perr = 0, n_pseen = 0, n_serr = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    assign ad_in = ad_oe_out ? ad_out : p_oe ? p_ad : b_oe ? b_ad : {8{cyc}};
    assign cbe_n_in = cbe_oe_out ? cbe_n_out : b_oe ? b_cbe : cyc;
    assign par_in = par_oe_out ? par_out : b_poe ? b_par : cyc[0];
    assign frame_n_in = frame_oe_out ? frame_n_out : b_frame;
    assign irdy_n_in = irdy_oe_out ? irdy_n_out : b_irdy;
    assign trdy_n_in = trdy_oe_out ? trdy_n_out : p_trdy;
    assign devsel_n_in = devsel_oe_out ? devsel_n_out : p_dev;
    assign stop_n_in = stop_oe_out ? stop_n_out : p_stop;
    pcitp_port DUT (.core_clk_in, .rst_in, .bus_reset_in, .ad_in, .ad_out, .ad_oe_out, .cbe_n_in, .cbe_n_out,
        .cbe_oe_out, .par_in, .par_out, .par_oe_out, .frame_n_in, .frame_n_out, .frame_oe_out, .irdy_n_in,
        .irdy_n_out, .irdy_oe_out, .trdy_n_in, .trdy_n_out, .trdy_oe_out, .devsel_n_in, .devsel_n_out,
        .devsel_oe_out, .stop_n_in, .stop_n_out, .stop_oe_out, .perr_n_in, .perr_n_out, .perr_oe_out, .serr_n_out,
        .serr_oe_out, .req_n_out, .req_oe_out, .gnt_n_in, .idsel_in, .cmd_reg_in, .bar_base_in, .bar_mask_in,
        .sys_err_in, .sec_addr_perr_in, .mreq_valid_in, .mreq_in, .mreq_ready_out, .mdone_out, .mabort_out,
        .mstop_out, .mrdata_out, .tacc_valid_out, .tacc_out, .trdata_in, .perr_seen_out);
    pcitp_bus_agent PEER (.core_clk_in, .mode_in(mode), .dly_in(dly), .ad_in, .cbe_n_in, .frame_n_in, .irdy_n_in,
        .ad_out(p_ad), .ad_oe_out(p_oe), .devsel_n_out(p_dev), .trdy_n_out(p_trdy), .stop_n_out(p_stop));
    task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    always @(posedge core_clk_in) begin
        cyc <= cyc + 4'h1;
        n_dev += (devsel_oe_out === 1'b1 && devsel_n_out === 1'b0);
        n_perr += (perr_oe_out === 1'b1 && perr_n_out === 1'b0);
        n_serr += (serr_oe_out === 1'b1 && serr_n_out === 1'b0);
        n_pseen += (perr_seen_out === 1'b1);
        if (tacc_valid_out === 1'b1) begin
            if (exp_q.size() == 0) chk("tacc_extra", 1, 0);
            else chk("tacc", tacc_out, exp_q.pop_front());
        end
    end
    // ------------------------
    // Initiator and target transfers
    // ------------------------
    task automatic mop(input logic wr, input logic [31:0] a, input logic [1:0] md, input logic [3:0] dl);
        logic [31:0] d;
        logic [3:0] c, be;
        int k;
        d = $random(seed);
        be = 4'($random(seed));
        c = wr ? CMD_MEM_WR : CMD_MEM_RD;
        mode <= md;
        dly <= dl;
        mreq_in <= '{wr, a, c, d, be, 1'b1};
        mreq_valid_in <= 1'b1;
        @(posedge core_clk_in);
        chk("req", {req_oe_out, req_n_out}, 2'b10);
        for (k = 0; k < 40 && mreq_ready_out !== 1'b1; k++) @(posedge core_clk_in);
        mreq_valid_in <= 1'b0;
        for (k = 0; k < 20 && !(frame_oe_out && frame_n_out === 1'b0); k++) @(posedge core_clk_in);
        chk("addr", {ad_out, cbe_n_out}, {a, c});
        @(posedge core_clk_in);
        chk("apar", par_out, ^{a, c});
        if (wr) chk("wdat", {ad_out, cbe_n_out, frame_n_out, irdy_n_out}, {d, ~be, 2'b10});
        @(posedge core_clk_in);
        if (wr) chk("dpar", par_out, ^{d, ~be});
        for (k = 0; k < 30 && !(mdone_out || mabort_out || mstop_out); k++) @(posedge core_clk_in);
        chk("end", {mdone_out, mabort_out, mstop_out}, md[1] ? 3'b001 : md[0] ? 3'b010 : 3'b100);
        if (!wr && md == 2'h0) chk("rdat", mrdata_out, a ^ 32'hA5A5_0F0F);
        repeat (4) @(posedge core_clk_in);
    endtask
    task automatic top(input logic cf, input logic [31:0] a, input logic ids, input logic bad, input logic hit);
        logic [31:0] d;
        logic [3:0] c, be;
        int k, n0, p0, s0;
        d = $random(seed);
        be = 4'($random(seed));
        c = cf ? CMD_CFG_WR : CMD_MEM_WR;
        if (hit) exp_q.push_back('{1'b1, cf, a, d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}, be});
        n0 = n_dev;
        p0 = n_perr;
        s0 = n_pseen;
        @(posedge core_clk_in);
        {b_oe, b_frame, b_ad, b_cbe, idsel_in} <= {2'b10, a, c, ids};
        @(posedge core_clk_in);
        {b_frame, b_irdy, b_ad, b_cbe, b_poe, b_par} <= {2'b10, d, ~be, 1'b1, ^{a, c}};
        for (k = 0; k < 12 && trdy_n_in !== 1'b0; k++) begin
            @(posedge core_clk_in);
            b_par <= ^{d, ~be} ^ bad;
        end
        {b_irdy, b_oe} <= 2'b10;
        @(posedge core_clk_in);
        {b_poe, idsel_in} <= 2'b00;
        repeat (10) @(posedge core_clk_in);
        chk("claim", n_dev > n0, hit);
        chk("perr", n_perr > p0, bad && hit && cmd_reg_in[6]);
        chk("pseen", n_pseen > s0, bad && hit);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        mop(1'b1, 32'h8000_0010, 2'h0, 4'h0);
        mop(1'b0, 32'h8000_0020, 2'h0, 4'h3);
        mop(1'b1, 32'h8000_0030, 2'h1, 4'h0);
        mop(1'b0, 32'h8000_0040, 2'h2, 4'h1);
        mode <= 2'h3;
        top(1'b0, 32'h4000_0100, 1'b0, 1'b0, 1'b1);
        top(1'b0, 32'h8000_0100, 1'b1, 1'b0, 1'b0);
        top(1'b1, 32'h0000_0010, 1'b1, 1'b0, 1'b1);
        top(1'b1, 32'h0000_0010, 1'b0, 1'b0, 1'b0);
        top(1'b0, 32'h4000_0200, 1'b0, 1'b1, 1'b1);
        cmd_reg_in <= 16'h0100;
        top(1'b0, 32'h4000_0300, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            n_serr = 0;
            cmd_reg_in <= {7'h00, i[0], 8'h40};
            @(posedge core_clk_in);
            {sec_addr_perr_in, sys_err_in} <= i[1] ? 2'b10 : 2'b01;
            @(posedge core_clk_in);
            {sec_addr_perr_in, sys_err_in} <= 2'b00;
            repeat (8) @(posedge core_clk_in);
            chk("serr", n_serr > 0, i[0]);
        end
        bus_reset_in <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        chk("float", {ad_oe_out, cbe_oe_out, par_oe_out, frame_oe_out, irdy_oe_out, trdy_oe_out, devsel_oe_out,
            stop_oe_out, perr_oe_out, serr_oe_out, req_oe_out}, 0);
        bus_reset_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        mop(1'b1, 32'h8000_0050, 2'h0, 4'h2);
        chk("left", exp_q.size(), 0);
        report_and_stop;
    end
endmodule
